// ===== hdl/ssb_defines.svh
// object indices, bit positions and reset values of the supply status bank
`ifndef SSB_DEFINES_SVH
`define SSB_DEFINES_SVH

`define SSB_IDX_QUES 16'h200B
`define SSB_IDX_STATUS 16'h200D
`define SSB_IDX_MEAS_CURR 16'h2101
`define SSB_IDX_MEAS_VOLT 16'h2102
`define SSB_IDX_CURR_WR 16'h2201
`define SSB_IDX_CURR_RD 16'h2202
`define SSB_IDX_VOLT_WR 16'h2203
`define SSB_IDX_VOLT_RD 16'h2204
`define SSB_SUB_STATUS_LOW 8'h00
`define SSB_SUB_STATUS_HIGH 8'h01
`define SSB_SUB_DEFAULT 8'h00

`define SSB_TARGET_RESET 32'h00000000
`define SSB_WORD_ZERO 32'h00000000

`define SSB_S0_STANDBY 0
`define SSB_S0_LIVE 1
`define SSB_S0_AMP_TRIP 4
`define SSB_S0_HIGH_VOLT_TRIP 5
`define SSB_S0_WATT_TRIP 6
`define SSB_S0_SENSE_BOUNDS 7
`define SSB_S0_LOW_VOLT_TRIP 8
`define SSB_S0_SHUTDOWN 9
`define SSB_S0_LINEAR_OVERLOAD 10
`define SSB_S0_RESISTOR_OVERLOAD 11
`define SSB_S0_START_FAILED 12
`define SSB_S0_START_PENDING 13
`define SSB_S0_LINE_CURRENT 14
`define SSB_S0_COMM 15
`define SSB_S0_TERM_AMP_LIMIT 16
`define SSB_S0_TERM_VOLT_LIMIT 17
`define SSB_S0_LINEAR_HOT 18
`define SSB_S0_AUX_FUSE 19
`define SSB_S0_INTERLOCK 20
`define SSB_S0_MAINTENANCE 22
`define SSB_S0_DIODE_HOT 23
`define SSB_S0_CONFIG_MISMATCH 24
`define SSB_S0_STACK_EXCEEDED 25
`define SSB_S0_IO_INPUT_FAULT 26
`define SSB_S0_RESISTOR_HOT 27
`define SSB_S0_UNDER_MINIMUM 28
`define SSB_S0_REGULATION_LOST 29
`define SSB_S0_TARGET_UPDATE 30

`define SSB_S1_PHASE_MISSING 0
`define SSB_S1_INPUT_FUSE 1
`define SSB_S1_FAN_STALLED 2
`define SSB_S1_POWER_STAGE_HOT 4
`define SSB_S1_FILTER_HOT 5
`define SSB_S1_CAPACITOR_HOT 6
`define SSB_S1_MAGNETICS_HOT 7
`define SSB_S1_RATING_INVALID 16
`define SSB_S1_FIRMWARE_MISMATCH 17

`define SSB_Q_VOLT_PROTECT 0
`define SSB_Q_AMP_TRIP 1
`define SSB_Q_VOLT_TRIP 2
`define SSB_Q_WATT_TRIP 3
`define SSB_Q_AMP_PROTECT 4
`define SSB_Q_TEMP_PROTECT 5
`define SSB_Q_SENSE_LOSS 6
`define SSB_Q_CONST_AMP 7
`define SSB_Q_CONST_VOLT 8
`define SSB_Q_CONST_OHM 9
`define SSB_Q_CONST_WATT 10
`define SSB_Q_ANY_SOFT 11
`define SSB_Q_ANY_HARD 12
`define SSB_Q_INTERLOCK 13
`define SSB_Q_INPUT_POWER 14
`define SSB_Q_INPUT_FAULT 15

`endif

// ===== hdl/ssb_pkg.sv
// types shared by the supply status and set-point bank
`default_nettype none
package ssb_pkg;

  typedef enum logic [2:0] {
    SSB_REG_NONE = 3'h0,
    SSB_REG_CONST_AMP = 3'h1,
    SSB_REG_CONST_VOLT = 3'h3,
    SSB_REG_CONST_OHM = 3'h2,
    SSB_REG_CONST_WATT = 3'h6
  } ssb_reg_mode_t;

  typedef struct packed {
    logic standby;
    logic live;
    logic amp_trip_flag;
    logic high_volt_trip_flag;
    logic watt_trip_flag;
    logic sense_bounds_flag;
    logic low_volt_trip_flag;
    logic shutdown;
    logic linear_module_overload;
    logic resistor_overload;
    logic target_start_failed;
    logic target_start_pending;
    logic line_current_exceeded;
    logic comm_corrupted;
    logic terminal_amp_limit;
    logic terminal_volt_limit;
    logic linear_module_hot;
    logic aux_fuse_open;
    logic interlock_open_flag;
    logic maintenance;
    logic diode_module_hot;
    logic config_mismatch;
    logic firmware_stack_exceeded;
    logic io_input_fault;
    logic resistor_module_hot;
    logic under_rated_minimum;
    logic regulation_lost;
    logic target_update_active;
    logic input_phase_missing;
    logic input_fuse_open;
    logic fan_stalled;
    logic power_stage_hot;
    logic output_filter_hot;
    logic output_capacitor_hot;
    logic magnetics_hot;
    logic rating_invalid;
    logic firmware_mismatch;
  } ssb_sources_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] index;
    logic [7:0] subindex;
    logic [31:0] data;
  } ssb_request_t;

  typedef struct packed {
    logic valid;
    logic error;
    logic [31:0] data;
  } ssb_response_t;

  typedef struct packed {
    logic [31:0] status_low;
    logic [31:0] status_high;
    logic [31:0] questionable;
    ssb_response_t rsp;
    logic [31:0] current_target;
    logic [31:0] voltage_target;
    logic [31:0] regulation_target;
  } ssb_state_t;

endpackage : ssb_pkg

`default_nettype wire

// ===== hdl/ssb_bank.sv
// status, measurement and set-point object bank of the supply
`timescale 1ns/1ps
`default_nettype none
`include "ssb_defines.svh"

module ssb_bank
  import ssb_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input var ssb_sources_t sources,
  input var ssb_reg_mode_t reg_mode,
  input wire logic [31:0] avg_terminal_current,
  input wire logic [31:0] avg_terminal_voltage,
  input wire logic [31:0] avg_sense_voltage,
  input wire logic sense_engaged,
  input var ssb_request_t req,
  output var ssb_response_t rsp,
  output logic [31:0] status_low,
  output logic [31:0] status_high,
  output logic [31:0] questionable,
  output logic [31:0] current_target,
  output logic [31:0] voltage_target,
  output logic [31:0] regulation_target
);

  ssb_state_t state;
  ssb_state_t next_state;

  // combinational copies of the live words, so a read answers with the
  // condition present in the request cycle rather than a stale snapshot
  logic [31:0] live_low;
  logic [31:0] live_high;
  logic [31:0] live_ques;
  logic [31:0] live_volt;
  logic soft_any;
  logic hard_any;
  logic temp_any;

  always_comb begin
    live_low = `SSB_WORD_ZERO;
    live_low[`SSB_S0_STANDBY] = sources.standby;
    live_low[`SSB_S0_LIVE] = sources.live;
    live_low[`SSB_S0_AMP_TRIP] = sources.amp_trip_flag;
    live_low[`SSB_S0_HIGH_VOLT_TRIP] = sources.high_volt_trip_flag;
    live_low[`SSB_S0_WATT_TRIP] = sources.watt_trip_flag;
    live_low[`SSB_S0_SENSE_BOUNDS] = sources.sense_bounds_flag;
    live_low[`SSB_S0_LOW_VOLT_TRIP] = sources.low_volt_trip_flag;
    live_low[`SSB_S0_SHUTDOWN] = sources.shutdown;
    live_low[`SSB_S0_LINEAR_OVERLOAD] = sources.linear_module_overload;
    live_low[`SSB_S0_RESISTOR_OVERLOAD] = sources.resistor_overload;
    live_low[`SSB_S0_START_FAILED] = sources.target_start_failed;
    live_low[`SSB_S0_START_PENDING] = sources.target_start_pending;
    live_low[`SSB_S0_LINE_CURRENT] = sources.line_current_exceeded;
    live_low[`SSB_S0_COMM] = sources.comm_corrupted;
    live_low[`SSB_S0_TERM_AMP_LIMIT] = sources.terminal_amp_limit;
    live_low[`SSB_S0_TERM_VOLT_LIMIT] = sources.terminal_volt_limit;
    live_low[`SSB_S0_LINEAR_HOT] = sources.linear_module_hot;
    live_low[`SSB_S0_AUX_FUSE] = sources.aux_fuse_open;
    live_low[`SSB_S0_INTERLOCK] = sources.interlock_open_flag;
    live_low[`SSB_S0_DIODE_HOT] = sources.diode_module_hot;
    live_low[`SSB_S0_RESISTOR_HOT] = sources.resistor_module_hot;
    live_low[`SSB_S0_MAINTENANCE] = sources.maintenance;
    live_low[`SSB_S0_CONFIG_MISMATCH] = sources.config_mismatch;
    live_low[`SSB_S0_STACK_EXCEEDED] = sources.firmware_stack_exceeded;
    live_low[`SSB_S0_IO_INPUT_FAULT] = sources.io_input_fault;
    live_low[`SSB_S0_UNDER_MINIMUM] = sources.under_rated_minimum;
    live_low[`SSB_S0_REGULATION_LOST] = sources.regulation_lost;
    live_low[`SSB_S0_TARGET_UPDATE] = sources.target_update_active;
  end

  always_comb begin
    live_high = `SSB_WORD_ZERO;
    live_high[`SSB_S1_PHASE_MISSING] = sources.input_phase_missing;
    live_high[`SSB_S1_INPUT_FUSE] = sources.input_fuse_open;
    live_high[`SSB_S1_FAN_STALLED] = sources.fan_stalled;
    live_high[`SSB_S1_POWER_STAGE_HOT] = sources.power_stage_hot;
    live_high[`SSB_S1_FILTER_HOT] = sources.output_filter_hot;
    live_high[`SSB_S1_CAPACITOR_HOT] = sources.output_capacitor_hot;
    live_high[`SSB_S1_MAGNETICS_HOT] = sources.magnetics_hot;
    live_high[`SSB_S1_RATING_INVALID] = sources.rating_invalid;
    live_high[`SSB_S1_FIRMWARE_MISMATCH] = sources.firmware_mismatch;
  end

  // the questionable word is a summary of the status sources; any module
  // over temperature counts as the single temperature hard fault
  always_comb begin
    temp_any = sources.linear_module_hot
             | sources.diode_module_hot
             | sources.resistor_module_hot
             | sources.power_stage_hot
             | sources.output_filter_hot
             | sources.output_capacitor_hot
             | sources.magnetics_hot;
    live_ques = `SSB_WORD_ZERO;
    live_ques[`SSB_Q_VOLT_PROTECT] = sources.terminal_volt_limit;
    live_ques[`SSB_Q_AMP_PROTECT] = sources.terminal_amp_limit;
    live_ques[`SSB_Q_TEMP_PROTECT] = temp_any;
    live_ques[`SSB_Q_SENSE_LOSS] = sources.sense_bounds_flag;
    live_ques[`SSB_Q_AMP_TRIP] = sources.amp_trip_flag;
    live_ques[`SSB_Q_VOLT_TRIP] = sources.high_volt_trip_flag;
    live_ques[`SSB_Q_WATT_TRIP] = sources.watt_trip_flag;
    live_ques[`SSB_Q_CONST_AMP] = (reg_mode == SSB_REG_CONST_AMP);
    live_ques[`SSB_Q_CONST_VOLT] = (reg_mode == SSB_REG_CONST_VOLT);
    live_ques[`SSB_Q_CONST_OHM] = (reg_mode == SSB_REG_CONST_OHM);
    live_ques[`SSB_Q_CONST_WATT] = (reg_mode == SSB_REG_CONST_WATT);
    soft_any = live_ques[`SSB_Q_AMP_TRIP]
             | live_ques[`SSB_Q_VOLT_TRIP]
             | live_ques[`SSB_Q_WATT_TRIP];
    hard_any = live_ques[`SSB_Q_VOLT_PROTECT]
             | live_ques[`SSB_Q_AMP_PROTECT]
             | live_ques[`SSB_Q_TEMP_PROTECT]
             | live_ques[`SSB_Q_SENSE_LOSS];
    live_ques[`SSB_Q_ANY_SOFT] = soft_any;
    live_ques[`SSB_Q_ANY_HARD] = hard_any;
    live_ques[`SSB_Q_INTERLOCK] = sources.interlock_open_flag;
    live_ques[`SSB_Q_INPUT_POWER] = sources.input_phase_missing | sources.input_fuse_open;
    live_ques[`SSB_Q_INPUT_FAULT] = sources.io_input_fault;
  end

  always_comb begin
    live_volt = sense_engaged ? avg_sense_voltage : avg_terminal_voltage;
  end

  always_comb begin
    next_state = state;
    // status words follow their sources every cycle; nothing holds them
    next_state.status_low = live_low;
    next_state.status_high = live_high;
    next_state.questionable = live_ques;
    next_state.rsp.valid = 1'b0;
    next_state.rsp.error = 1'b0;
    next_state.rsp.data = state.rsp.data;
    if (req.valid && !req.write) begin
      next_state.rsp.valid = 1'b1;
      // reads only select a value, so a query leaves every word untouched
      case (req.index)
        `SSB_IDX_QUES: begin
          next_state.rsp.data = live_ques;
        end
        `SSB_IDX_STATUS: begin
          if (req.subindex == `SSB_SUB_STATUS_LOW) begin
            next_state.rsp.data = live_low;
          end else if (req.subindex == `SSB_SUB_STATUS_HIGH) begin
            next_state.rsp.data = live_high;
          end else begin
            next_state.rsp.data = `SSB_WORD_ZERO;
            next_state.rsp.error = 1'b1;
          end
        end
        `SSB_IDX_MEAS_CURR: begin
          next_state.rsp.data = avg_terminal_current;
        end
        `SSB_IDX_MEAS_VOLT: begin
          next_state.rsp.data = live_volt;
        end
        `SSB_IDX_CURR_WR, `SSB_IDX_CURR_RD: begin
          next_state.rsp.data = state.current_target;
        end
        `SSB_IDX_VOLT_WR, `SSB_IDX_VOLT_RD: begin
          next_state.rsp.data = state.voltage_target;
        end
        default: begin
          next_state.rsp.data = `SSB_WORD_ZERO;
          next_state.rsp.error = 1'b1;
        end
      endcase
    end else if (req.valid && req.write) begin
      next_state.rsp.valid = 1'b1;
      next_state.rsp.data = `SSB_WORD_ZERO;
      case (req.index)
        `SSB_IDX_CURR_WR: begin
          next_state.current_target = req.data;
        end
        `SSB_IDX_VOLT_WR: begin
          next_state.voltage_target = req.data;
        end
        default: begin
          // read-only and unknown objects keep their contents
          next_state.rsp.error = 1'b1;
        end
      endcase
    end
    // the loop reference follows the mode; outside current and voltage regulation the loop
    // owns its own target, so the voltage target is held as a safe default
    case (reg_mode)
      SSB_REG_CONST_AMP: begin
        next_state.regulation_target = next_state.current_target;
      end
      SSB_REG_CONST_VOLT: begin
        next_state.regulation_target = next_state.voltage_target;
      end
      default: begin
        next_state.regulation_target = next_state.voltage_target;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state.status_low <= `SSB_WORD_ZERO;
      state.status_high <= `SSB_WORD_ZERO;
      state.questionable <= `SSB_WORD_ZERO;
      state.rsp.valid <= 1'b0;
      state.rsp.error <= 1'b0;
      state.rsp.data <= `SSB_WORD_ZERO;
      state.current_target <= `SSB_TARGET_RESET;
      state.voltage_target <= `SSB_TARGET_RESET;
      state.regulation_target <= `SSB_TARGET_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign rsp = state.rsp;
  assign status_low = state.status_low;
  assign status_high = state.status_high;
  assign questionable = state.questionable;
  assign current_target = state.current_target;
  assign voltage_target = state.voltage_target;
  assign regulation_target = state.regulation_target;

endmodule : ssb_bank

`default_nettype wire

// ===== sim/ssb_bank_properties.sv
// port-level checks of the supply status bank
`timescale 1ns/1ps
`default_nettype none
module ssb_bank_properties
  import ssb_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input var ssb_sources_t sources,
  input var ssb_reg_mode_t reg_mode,
  input wire logic [31:0] avg_terminal_current,
  input wire logic [31:0] avg_terminal_voltage,
  input wire logic [31:0] avg_sense_voltage,
  input wire logic sense_engaged,
  input var ssb_request_t req,
  input var ssb_response_t rsp,
  input wire logic [31:0] status_low,
  input wire logic [31:0] status_high,
  input wire logic [31:0] questionable,
  input wire logic [31:0] current_target,
  input wire logic [31:0] voltage_target,
  input wire logic [31:0] regulation_target
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic rd_req;
  logic wr_req;
  assign rd_req = req.valid && !req.write;
  assign wr_req = req.valid && req.write;
  // the first edge after release still sees reset-time words, hence the past guard
  a_status_live: assert property (!$past(sys_rst) |->
    status_low[1:0] == {$past(sources.live), $past(sources.standby)}) else $error("status word stale");
  a_spare_zero: assert property (status_low[3:2] == 0 && !status_low[21] && !status_low[31] &&
    !status_high[3] && status_high[15:8] == 0 && status_high[31:18] == 0) else $error("spare bit set");
  a_soft_or: assert property (questionable[11] == (|questionable[3:1]))
    else $error("soft summary wrong");
  a_hard_or: assert property (questionable[12] == (questionable[0] || (|questionable[6:4])))
    else $error("hard summary wrong");
  a_trip_bits: assert property (!$past(sys_rst) |-> questionable[3:1] ==
    {$past(sources.watt_trip_flag), $past(sources.high_volt_trip_flag), $past(sources.amp_trip_flag)})
    else $error("trip bits wrong");
  a_mode_bits: assert property (!$past(sys_rst) |-> questionable[10:7] ==
    {$past(reg_mode) == SSB_REG_CONST_WATT, $past(reg_mode) == SSB_REG_CONST_OHM,
     $past(reg_mode) == SSB_REG_CONST_VOLT, $past(reg_mode) == SSB_REG_CONST_AMP}) else $error("mode bits wrong");
  a_amp_read: assert property (rd_req && req.index == 16'h2101 |=>
    rsp.valid && !rsp.error && rsp.data == $past(avg_terminal_current)) else $error("current read wrong");
  a_volt_read: assert property (rd_req && req.index == 16'h2102 |=> rsp.valid && rsp.data ==
    ($past(sense_engaged) ? $past(avg_sense_voltage) : $past(avg_terminal_voltage))) else $error("voltage read wrong");
  a_ro_write: assert property (wr_req && req.index != 16'h2201 && req.index != 16'h2203 |=>
    rsp.error && $stable(current_target) && $stable(voltage_target)) else $error("read-only write took effect");
  a_volt_write: assert property (wr_req && req.index == 16'h2203 |=>
    voltage_target == $past(req.data) && !rsp.error) else $error("voltage target not written");
  a_target_use: assert property (!$past(sys_rst) |-> regulation_target ==
    ($past(reg_mode) == SSB_REG_CONST_AMP ? current_target : voltage_target)) else $error("wrong target in use");
  c_ques_read: cover property (rd_req && req.index == 16'h200B);
  c_volt_write: cover property (wr_req && req.index == 16'h2203);
  c_sense_read: cover property (rd_req && req.index == 16'h2102 && sense_engaged);
endmodule : ssb_bank_properties
`default_nettype wire

// ===== sim/ssb_master.sv
// fieldbus master model issuing object reads and writes
`timescale 1ns/1ps
`default_nettype none
module ssb_master
  import ssb_pkg::*;
(
  input wire logic clk,
  output var ssb_request_t req,
  input var ssb_response_t rsp
);
  initial req = '0;
  // entered just after an edge; request stays up so calls in a row go back to back
  task automatic xfer(input logic w, input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] d,
                      output ssb_response_t r);
    req = '{valid: 1'b1, write: w, index: idx, subindex: sub, data: d};
    @(posedge clk);
    #1;
    r = rsp;
  endtask : xfer
  // a released request drops valid and inverts its index and data; write and subindex keep their last values
  task automatic idle();
    req.valid = 1'b0;
    req.index = ~req.index;
    req.data = ~req.data;
  endtask : idle
endmodule : ssb_master
`default_nettype wire

// ===== sim/ssb_bank_tb.sv
// self-checking bench of the supply status bank
`timescale 1ns/1ps
`default_nettype none
module ssb_bank_tb
  import ssb_pkg::*;
;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  ssb_sources_t sources = '0;
  ssb_reg_mode_t reg_mode = SSB_REG_NONE;
  logic [31:0] avg_terminal_current = '0;
  logic [31:0] avg_terminal_voltage = '0;
  logic [31:0] avg_sense_voltage = '0;
  logic sense_engaged = 1'b0;
  ssb_request_t req;
  ssb_response_t rsp;
  logic [31:0] status_low, status_high, questionable, current_target, voltage_target, regulation_target;
  int fail_count = 0;
  int num_checks = 0;
  int pos [37] = '{0, 1, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15, 16, 17, 18, 19, 20, 22, 23, 24, 25, 26, 27, 28,
                   29, 30, 32, 33, 34, 36, 37, 38, 39, 48, 49};
  logic [31:0] qexp [5] = '{32'h0, 32'h80, 32'h100, 32'h200, 32'h400};
  ssb_reg_mode_t modes [5] = '{SSB_REG_NONE, SSB_REG_CONST_AMP, SSB_REG_CONST_VOLT, SSB_REG_CONST_OHM,
                               SSB_REG_CONST_WATT};
  logic [15:0] ro_idx [6] = '{16'h200B, 16'h200D, 16'h2101, 16'h2102, 16'h2202, 16'h2204};
  always #2.5 clk = ~clk;
  ssb_bank dut (.clk(clk), .sys_rst(sys_rst), .sources(sources), .reg_mode(reg_mode),
    .avg_terminal_current(avg_terminal_current), .avg_terminal_voltage(avg_terminal_voltage),
    .avg_sense_voltage(avg_sense_voltage), .sense_engaged(sense_engaged), .req(req), .rsp(rsp),
    .status_low(status_low), .status_high(status_high), .questionable(questionable),
    .current_target(current_target), .voltage_target(voltage_target), .regulation_target(regulation_target));
  ssb_master master (.clk(clk), .req(req), .rsp(rsp));
  // summary word expected for one source raised alone, keyed by its status bit position
  function automatic logic [31:0] ques_of(int p);
    case (p)
      4: return 32'h802;
      5: return 32'h804;
      6: return 32'h808;
      7: return 32'h1040;
      16: return 32'h1010;
      17: return 32'h1001;
      18, 23, 27, 36, 37, 38, 39: return 32'h1020;
      20: return 32'h2000;
      26: return 32'h8000;
      32, 33: return 32'h4000;
      default: return 32'h0;
    endcase
  endfunction : ques_of
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] d,
                     input logic [31:0] exp, input logic err);
    ssb_response_t r;
    master.xfer(w, idx, sub, d, r);
    chk({31'h0, r.valid}, 32'h1, "answer valid");
    chk({31'h0, r.error}, {31'h0, err}, "answer error");
    chk(r.data, exp, "answer data");
  endtask : acc
  task automatic rd(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] exp, input logic err);
    acc(1'b0, idx, sub, 32'h0, exp, err);
  endtask : rd
  task automatic wr(input logic [15:0] idx, input logic [31:0] d, input logic err);
    acc(1'b1, idx, 8'h00, d, 32'h0, err);
  endtask : wr
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test
  initial begin
    #100000;
    fail_count++;
    finish_test();
  end
  initial begin
    repeat (10) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    @(posedge clk);
    #1;
    chk(current_target, 32'h0, "current target reset");
    rd(16'h2204, 8'h00, 32'h0, 1'b0);
    for (int i = 0; i < 37; i++) begin
      logic [63:0] e;
      e = 64'h1 << pos[i];
      sources = ssb_sources_t'(37'h1 << (36 - i));
      rd(16'h200D, 8'h00, e[31:0], 1'b0);
      rd(16'h200D, 8'h00, e[31:0], 1'b0);
      rd(16'h200D, 8'h01, e[63:32], 1'b0);
      rd(16'h200B, 8'h00, ques_of(pos[i]), 1'b0);
      chk(status_low, e[31:0], "live low word");
      chk(status_high, e[63:32], "live high word");
      chk(questionable, ques_of(pos[i]), "live summary");
    end
    sources = '0;
    avg_terminal_current = 32'h3FC00000;
    avg_terminal_voltage = 32'h41480000;
    avg_sense_voltage = 32'h41400000;
    rd(16'h2101, 8'h00, 32'h3FC00000, 1'b0);
    rd(16'h2102, 8'h00, 32'h41480000, 1'b0);
    sense_engaged = 1'b1;
    rd(16'h2102, 8'h00, 32'h41400000, 1'b0);
    wr(16'h2201, 32'h40A00000, 1'b0);
    wr(16'h2203, 32'h42480000, 1'b0);
    rd(16'h2202, 8'h00, 32'h40A00000, 1'b0);
    for (int i = 0; i < 6; i++) begin
      wr(ro_idx[i], 32'hDEADBEEF, 1'b1);
      rd(16'h2204, 8'h00, 32'h42480000, 1'b0);
    end
    chk(current_target, 32'h40A00000, "current target kept");
    rd(16'h2103, 8'h00, 32'h0, 1'b1);
    rd(16'h200D, 8'h02, 32'h0, 1'b1);
    for (int i = 0; i < 5; i++) begin
      reg_mode = modes[i];
      rd(16'h200B, 8'h00, qexp[i], 1'b0);
      chk(regulation_target, (i == 1) ? 32'h40A00000 : 32'h42480000, "target in use");
    end
    master.idle();
    sys_rst = 1'b1;
    @(posedge clk);
    #1;
    chk(voltage_target, 32'h0, "target cleared");
    sys_rst = 1'b0;
    @(posedge clk);
    #1;
    rd(16'h2202, 8'h00, 32'h0, 1'b0);
    finish_test();
  end
endmodule : ssb_bank_tb
bind ssb_bank ssb_bank_properties u_props (.clk(clk), .sys_rst(sys_rst), .sources(sources), .reg_mode(reg_mode),
  .avg_terminal_current(avg_terminal_current), .avg_terminal_voltage(avg_terminal_voltage),
  .avg_sense_voltage(avg_sense_voltage), .sense_engaged(sense_engaged), .req(req), .rsp(rsp),
  .status_low(status_low), .status_high(status_high), .questionable(questionable),
  .current_target(current_target), .voltage_target(voltage_target), .regulation_target(regulation_target));
`default_nettype wire
